// File: design/spi_crc_register_port.sv
// Function
// - Serial transfers only while select low; output released when high.
// - Host changes input on rising edge; device samples on falling edge.
// - Device changes output on rising edge; host samples on falling edge.
// - Both directions shift most significant bit first.
// - Every transaction is exactly 40 clocked bits in one select period.
// - First input bit one selects a register write.
// - First input bit zero selects a register read.
// - During a write frame the output carries only filler.
// - Writes to unimplemented bit positions are discarded.
// - Read answer: 8 filler, data byte, 16 filler, checksum.
// - Outgoing read checksum covers only the 8 data bits.
// - All checksums are CRC-8 with polynomial x8+x4+x3+x2+1.
// - Bad write checksum leaves the addressed register unchanged.
// - Bad read checksum yields a wrong outgoing checksum that frame.
// - During undervoltage ignore transactions and hold output low.
// - Missing register or length not 40 sets the error flag.
// - Filler bit values never affect the operation.
`timescale 1ns/1ps
`default_nettype none
module spi_crc_register_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic cs_n,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic serial_out_oe,
  input wire logic vcc_uv,
  input wire logic err_clear,
  output logic err_spi,
  output logic wr_strobe,
  output spi_crc_pkg::wr_cmd_type wr_cmd
);

  // ****************************************
  // Link side, sampling on the falling edge
  // ****************************************
  logic fresh_reg, fresh_next;
  logic seq_reg, seq_next;
  logic rw_reg, rw_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [39:0] shift_reg, shift_next;

  always_comb begin
    fresh_next = fresh_reg;
    seq_next = seq_reg;
    rw_next = rw_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    if (!cs_n) begin
      fresh_next = 1'b0;
      shift_next = {shift_reg[38:0], serial_in_line};
      if (fresh_reg) begin
        seq_next = ~seq_reg;
        rw_next = serial_in_line;
        cnt_next = 6'h01;
      end else if (cnt_reg != spi_crc_pkg::CNT_MAX) begin
        cnt_next = cnt_reg + 6'h01;
      end
    end
  end

  // Marks the next falling edge as the frame's first bit
  always_ff @(negedge serial_clk or negedge rst_n or posedge cs_n) begin
    if (!rst_n) begin
      fresh_reg <= 1'b1;
    end else if (cs_n) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= fresh_next;
    end
  end

  // Not cleared by chip select: the other side reads them after the frame
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= 1'b0;
      rw_reg <= 1'b0;
      cnt_reg <= 6'h00;
      shift_reg <= 40'h00_0000_0000;
    end else begin
      seq_reg <= seq_next;
      rw_reg <= rw_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
    end
  end

  // ****************************************
  // Link side, driving on the rising edge
  // ****************************************
  logic [5:0] tx_idx;
  logic tx_bit_reg, tx_bit_next;
  logic crc_bad_reg, crc_bad_next;
  logic rd_re;
  logic [7:0] rd_data;
  logic [7:0] rd_crc;
  logic [7:0] rx_crc;
  logic [7:0] tx_crc;
  logic [2:0] sub_idx;

  crc8_calc #(.WIDTH(16)) u_rx_crc (
    .data(shift_reg[spi_crc_pkg::RX_HDR_LSB +: 16]),
    .crc(rx_crc)
  );

  crc8_calc #(.WIDTH(8)) u_tx_crc (
    .data(rd_data),
    .crc(rd_crc)
  );

  always_comb begin
    tx_idx = fresh_reg ? 6'h00 : cnt_reg;
    sub_idx = 3'h7 - tx_idx[2:0];
    rd_re = !cs_n && !fresh_reg && cnt_reg == spi_crc_pkg::CNT_ADDR_DONE;
    crc_bad_next = crc_bad_reg;
    if (!cs_n && !fresh_reg && cnt_reg == spi_crc_pkg::CNT_RXCRC_DONE) begin
      // Filler bits are folded into the check as sent, never decoded
      crc_bad_next = rx_crc != shift_reg[7:0];
    end
    // Inverting the whole field guarantees a mismatch at the host
    tx_crc = crc_bad_reg ? ~rd_crc : rd_crc;
    tx_bit_next = tx_bit_reg;
    if (!cs_n) begin
      tx_bit_next = 1'b0;
      if (rw_reg || fresh_reg) begin
        tx_bit_next = 1'b0;
      end else if (tx_idx >= spi_crc_pkg::TX_CRC_FIRST) begin
        tx_bit_next = tx_crc[sub_idx];
      end else if (tx_idx >= spi_crc_pkg::TX_DATA_FIRST &&
                   tx_idx < spi_crc_pkg::TX_PAD_FIRST) begin
        tx_bit_next = rd_data[sub_idx];
      end
    end
  end

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_reg <= 1'b0;
      crc_bad_reg <= 1'b0;
    end else begin
      tx_bit_reg <= tx_bit_next;
      crc_bad_reg <= crc_bad_next;
    end
  end

  // ****************************************
  // Register storage
  // ****************************************
  logic mem_we;
  spi_crc_pkg::wr_cmd_type mem_cmd;

  reg_bank #(.DEPTH(spi_crc_pkg::REG_DEPTH)) u_bank (
    .wr_clk(ref_clk),
    .rst_n(rst_n),
    .we(mem_we),
    .wr_cmd(mem_cmd),
    .rd_clk(serial_clk),
    .re(rd_re),
    .raddr(shift_reg[4:0]),
    .rd_data(rd_data)
  );

  // ****************************************
  // Oscillator side: frame end and commit
  // ****************************************
  logic [2:0] cs_sync_reg, cs_sync_next;
  logic [1:0] uv_sync_reg, uv_sync_next;
  logic last_seq_reg, last_seq_next;
  logic err_reg, err_next;
  logic wr_strobe_reg, wr_strobe_next;
  spi_crc_pkg::wr_cmd_type wr_cmd_reg, wr_cmd_next;
  spi_crc_pkg::link_frame_type snap;
  logic frame_end;
  logic uv;
  logic full;
  logic present;
  logic [7:0] fr_mask;

  always_comb begin
    cs_sync_next = {cs_sync_reg[1:0], cs_n};
    uv_sync_next = {uv_sync_reg[0], vcc_uv};
    uv = uv_sync_reg[1];
    frame_end = cs_sync_reg[1] && !cs_sync_reg[2];
    // Link registers are idle while select is high, so they are read here
    snap = '{seq: seq_reg, cnt: cnt_reg, crc_bad: crc_bad_reg,
             bits: shift_reg};
    full = snap.seq != last_seq_reg &&
           snap.cnt == spi_crc_pkg::CNT_FULL;
    mem_cmd.addr = snap.bits[spi_crc_pkg::POS_ADDR_LSB +: 5];
    mem_cmd.data = snap.bits[spi_crc_pkg::POS_DATA_LSB +: 8];
    fr_mask = spi_crc_pkg::reg_mask(mem_cmd.addr);
    present = fr_mask != 8'h00;
    mem_we = frame_end && !uv && full &&
             present && !snap.crc_bad &&
             snap.bits[spi_crc_pkg::POS_RW];
    last_seq_next = frame_end ? snap.seq : last_seq_reg;
    err_next = err_reg;
    if (err_clear) begin
      err_next = 1'b0;
    end
    // Setting wins over a clear in the same cycle
    if (frame_end && !uv && (!full || !present)) begin
      err_next = 1'b1;
    end
    wr_strobe_next = mem_we;
    wr_cmd_next = wr_cmd_reg;
    if (mem_we) begin
      wr_cmd_next.addr = mem_cmd.addr;
      wr_cmd_next.data = (mem_cmd.data & fr_mask) |
        (spi_crc_pkg::reg_reset(mem_cmd.addr) & ~fr_mask);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      uv_sync_reg <= 2'h0;
      last_seq_reg <= 1'b0;
      err_reg <= 1'b0;
      wr_strobe_reg <= 1'b0;
      wr_cmd_reg <= '0;
    end else begin
      cs_sync_reg <= cs_sync_next;
      uv_sync_reg <= uv_sync_next;
      last_seq_reg <= last_seq_next;
      err_reg <= err_next;
      wr_strobe_reg <= wr_strobe_next;
      wr_cmd_reg <= wr_cmd_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign serial_out_oe = !cs_n;
  assign serial_out_line = !uv && !fresh_reg && tx_bit_reg;
  assign err_spi = err_reg;
  assign wr_strobe = wr_strobe_reg;
  assign wr_cmd = wr_cmd_reg;

  // ****************************************
  // Assertions
  // ****************************************
  a_uv_no_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    uv |-> !mem_we)
    else $error("write committed in undervoltage");

  a_commit_full: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    mem_we |-> snap.cnt == spi_crc_pkg::CNT_FULL && frame_end)
    else $error("write commit without a full frame end");

  a_short_no_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    frame_end && snap.cnt != spi_crc_pkg::CNT_FULL
    |-> !mem_we ##1 !wr_strobe)
    else $error("wrong length frame wrote");

  a_crc_blocks: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    frame_end && snap.crc_bad |=> !wr_strobe)
    else $error("bad checksum frame wrote");

  a_write_select: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_strobe |-> $past(snap.bits[spi_crc_pkg::POS_RW]) &&
    wr_cmd.addr == $past(mem_cmd.addr))
    else $error("strobe without write select or wrong address");

  a_err_length: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    frame_end && !uv && snap.cnt != spi_crc_pkg::CNT_FULL
    |=> err_spi [*2])
    else $error("length error not flagged");

  a_err_sticky: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    err_spi && !err_clear |=> err_spi)
    else $error("error flag dropped without clear");

  a_mask_kept: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    wr_strobe |-> (wr_cmd.data & ~spi_crc_pkg::reg_mask(wr_cmd.addr)) ==
    (spi_crc_pkg::reg_reset(wr_cmd.addr) &
     ~spi_crc_pkg::reg_mask(wr_cmd.addr)))
    else $error("unimplemented bits changed");

  a_write_quiet: assert property (
    @(posedge serial_clk) disable iff (!rst_n)
    !cs_n && rw_reg && !fresh_reg |=> !tx_bit_reg)
    else $error("write frame output not filler");

  a_read_msb: assert property (
    @(posedge serial_clk) disable iff (!rst_n)
    !cs_n && !rw_reg && !fresh_reg && cnt_reg == spi_crc_pkg::TX_DATA_FIRST
    |=> tx_bit_reg == rd_data[7])
    else $error("read data MSB not first");

  a_read_crc: assert property (
    @(posedge serial_clk) disable iff (!rst_n)
    !cs_n && !rw_reg && !fresh_reg && cnt_reg == spi_crc_pkg::TX_CRC_FIRST
    |=> tx_bit_reg == (crc_bad_reg ^ rd_crc[7]))
    else $error("read checksum MSB wrong");

  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mem_we);
  c_len_err: cover property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && !full);
  c_crc_bad: cover property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && snap.crc_bad && full);
  c_uv_frame: cover property (@(posedge ref_clk) disable iff (!rst_n)
    frame_end && uv);

endmodule : spi_crc_register_port
`default_nettype wire

// File: design/spi_crc_pkg.sv
package spi_crc_pkg;

  localparam int FRAME_BITS = 40;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int CRC_W = 8;
  localparam int REG_DEPTH = 32;

  // CRC generator x^8 + x^4 + x^3 + x^2 + 1, shifted MSB first
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Bit counter landmarks (count of bits already sampled)
  localparam logic [5:0] CNT_FULL = 6'h28;
  localparam logic [5:0] CNT_MAX = 6'h3f;
  localparam logic [5:0] CNT_ADDR_DONE = 6'h06;
  localparam logic [5:0] CNT_RXCRC_DONE = 6'h18;

  // Outgoing field starts, in bit times from the frame start
  localparam logic [5:0] TX_DATA_FIRST = 6'h08;
  localparam logic [5:0] TX_PAD_FIRST = 6'h10;
  localparam logic [5:0] TX_CRC_FIRST = 6'h20;

  // Field positions of a complete frame, first bit at the top
  localparam int POS_RW = 39;
  localparam int POS_ADDR_LSB = 34;
  localparam int POS_DATA_LSB = 24;
  // Header and checksum in the shifter after 24 bits
  localparam int RX_HDR_LSB = 8;

  typedef struct packed {
    logic seq;
    logic [5:0] cnt;
    logic crc_bad;
    logic [39:0] bits;
  } link_frame_type;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } wr_cmd_type;

  // Implemented bits per address; zero mask means no register
  function automatic logic [7:0] reg_mask(input logic [4:0] addr);
    case (addr)
      5'h01: reg_mask = 8'hfe;
      5'h02: reg_mask = 8'h1f;
      5'h03: reg_mask = 8'hfe;
      5'h04: reg_mask = 8'h7f;
      5'h05: reg_mask = 8'hff;
      5'h06: reg_mask = 8'h03;
      5'h07: reg_mask = 8'ha0;
      5'h08: reg_mask = 8'h38;
      default: reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] reg_reset(input logic [4:0] addr);
    case (addr)
      5'h01: reg_reset = 8'hf4;
      5'h02: reg_reset = 8'h0c;
      5'h03: reg_reset = 8'h48;
      5'h04: reg_reset = 8'h11;
      default: reg_reset = 8'h00;
    endcase
  endfunction : reg_reset

endpackage : spi_crc_pkg

// File: design/crc8_calc.sv
`timescale 1ns/1ps
`default_nettype none
module crc8_calc #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data,
  output logic [7:0] crc
);

  always_comb begin
    logic fb;
    fb = 1'b0;
    crc = spi_crc_pkg::CRC_INIT;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      fb = crc[7] ^ data[i];
      crc = {crc[6:0], 1'b0} ^ (fb ? spi_crc_pkg::CRC_POLY : 8'h00);
    end
  end

endmodule : crc8_calc
`default_nettype wire

// File: design/reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module reg_bank #(
  parameter int DEPTH = 32
) (
  input wire logic wr_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire spi_crc_pkg::wr_cmd_type wr_cmd,
  input wire logic rd_clk,
  input wire logic re,
  input wire logic [4:0] raddr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] mem_next [DEPTH];
  logic [7:0] rd_next;

  // ****************************************
  // Storage, written from the oscillator side
  // ****************************************
  for (genvar a = 0; a < DEPTH; a++) begin : g_word
    localparam logic [4:0] ADDR = 5'(a);
    localparam logic [7:0] MASK = spi_crc_pkg::reg_mask(ADDR);
    localparam logic [7:0] RST = spi_crc_pkg::reg_reset(ADDR);
    always_comb begin
      mem_next[a] = mem_reg[a];
      if (we && wr_cmd.addr == ADDR) begin
        mem_next[a] = (wr_cmd.data & MASK) | (RST & ~MASK);
      end
    end
    always_ff @(posedge wr_clk or negedge rst_n) begin
      if (!rst_n) begin
        mem_reg[a] <= RST;
      end else begin
        mem_reg[a] <= mem_next[a];
      end
    end
  end

  // ****************************************
  // Read port on the link clock
  // ****************************************
  // Words change only between frames, so the link side reads them live
  always_comb begin
    rd_next = re ? mem_reg[raddr] : rd_data;
  end

  always_ff @(posedge rd_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_next;
    end
  end

endmodule : reg_bank
`default_nettype wire

// File: dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic serial_clk,
  output logic cs_n,
  output logic serial_in_line,
  input wire logic miso
);
  // ****************
  // Frame engine
  // ****************
  initial begin
    serial_clk = 1'b0;
    cs_n = 1'b1;
    serial_in_line = 1'b0;
  end

  // Clock runs only inside frames, 30 ns period
  task automatic xfer(input logic [40:0] tx, input int n,
                      output logic [39:0] rx);
    rx = '0;
    cs_n = 1'b0;
    #17;
    for (int i = 0; i < n; i++) begin
      serial_clk = 1'b1;
      serial_in_line = tx[40-i];
      #15;
      serial_clk = 1'b0;
      rx = {rx[38:0], miso};
      #15;
    end
    // Input has a pull-down once released
    serial_in_line = 1'b0;
    #15;
    cs_n = 1'b1;
    // Gap covers the commit latency of the frame just ended
    #450;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// File: dv/tb_spi_crc_register_port.sv
`timescale 1ns/1ps
`default_nettype none
module tb_spi_crc_register_port;
  logic ref_clk = 1'b0;
  logic rst_n;
  logic vcc_uv = 1'b0;
  logic err_clear = 1'b0;
  wire logic serial_clk;
  wire logic cs_n;
  wire logic serial_in_line;
  wire logic miso;
  logic serial_out_line;
  logic serial_out_oe;
  logic err_spi;
  logic wr_strobe;
  spi_crc_pkg::wr_cmd_type wr_cmd;
  spi_crc_pkg::wr_cmd_type last_cmd;
  int error_cnt = 0;
  int checks = 0;
  int strobes = 0;
  logic [7:0] shadow [32];

  always #25 ref_clk = ~ref_clk;
  assign miso = serial_out_oe ? serial_out_line : 1'bz;

  spi_crc_register_port uut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .serial_clk(serial_clk),
    .cs_n(cs_n),
    .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line),
    .serial_out_oe(serial_out_oe),
    .vcc_uv(vcc_uv),
    .err_clear(err_clear),
    .err_spi(err_spi),
    .wr_strobe(wr_strobe),
    .wr_cmd(wr_cmd)
  );

  spi_host_model host (
    .serial_clk(serial_clk),
    .cs_n(cs_n),
    .serial_in_line(serial_in_line),
    .miso(miso)
  );

  always @(posedge ref_clk) begin
    if (wr_strobe === 1'b1) begin
      strobes++;
      last_cmd = wr_cmd;
    end
  end

  // ****************
  // Expectations
  // ****************
  function automatic logic [7:0] crc8(input logic [15:0] d, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1d : 8'h00);
    end
    return c;
  endfunction : crc8

  function automatic logic [7:0] mask_of(input logic [4:0] a);
    logic [7:0] m [9];
    m = '{8'h00, 8'hfe, 8'h1f, 8'hfe, 8'h7f, 8'hff, 8'h03, 8'ha0, 8'h38};
    return (a < 5'h09) ? m[a] : 8'h00;
  endfunction : mask_of

  task automatic chk_word(input logic [39:0] got, input logic [39:0] exp,
                          input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // ****************
  // Frame tasks
  // ****************
  task automatic post(input logic exp_err);
    chk_bit(serial_out_oe, 1'b0, "output released");
    chk_bit(err_spi, exp_err, "error flag");
    @(negedge ref_clk) err_clear = 1'b1;
    @(negedge ref_clk) err_clear = 1'b0;
    @(negedge ref_clk);
    chk_bit(err_spi, 1'b0, "error cleared");
  endtask : post

  task automatic do_read(input logic [4:0] a, input logic bad);
    logic [15:0] hdr;
    logic [7:0] d;
    logic [39:0] rx;
    logic [39:0] exp;
    hdr = {1'b0, a, 10'($urandom)};
    host.xfer({hdr, crc8(hdr, 16) ^ {8{bad}}, 16'($urandom), 1'b0}, 40,
              rx);
    d = shadow[a];
    exp = {8'h00, d, 16'h0000, crc8({8'h00, d}, 8) ^ {8{bad}}};
    if (vcc_uv) exp = 40'h0;
    chk_word(rx, exp, "read frame");
    post(mask_of(a) == 8'h00 && !vcc_uv);
  endtask : do_read

  task automatic do_write(input logic [4:0] a, input logic [7:0] d,
                          input logic bad, input int n);
    logic [15:0] hdr;
    logic [39:0] rx;
    logic [7:0] m;
    logic ok;
    int s0;
    hdr = {1'b1, a, 2'($urandom), d};
    m = mask_of(a);
    s0 = strobes;
    host.xfer({hdr, crc8(hdr, 16) ^ {8{bad}}, 16'($urandom), 1'b0}, n,
              rx);
    if (n == 40) chk_word(rx, 40'h0, "write filler");
    ok = !bad && n == 40 && !vcc_uv;
    chk_bit(strobes == s0 + ok, 1'b1, "wr");
    if (ok) begin
      chk_word({35'h0, last_cmd.addr}, {35'h0, a}, "cmd addr");
      shadow[a] = (shadow[a] & ~m) | (d & m);
      chk_word(40'(last_cmd.data), 40'(shadow[a]), "cmd data");
    end
    post(n != 40 && !vcc_uv);
    do_read(a, 1'b0);
  endtask : do_write

  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // ****************
  // Sequence
  // ****************
  initial begin
    #1ms;
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    void'($urandom(32'ha6820aaf));
    shadow = '{default: 8'h00};
    shadow[1] = 8'hf4;
    shadow[2] = 8'h0c;
    shadow[3] = 8'h48;
    shadow[4] = 8'h11;
    // Real falling edge after time zero, so the link domain resets too
    #1 rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    for (int a = 0; a < 32; a++) begin
      do_read(5'(a), 1'b0);
    end
    do_write(5'h05, 8'h00, 1'b0, 40);
    do_write(5'h05, 8'hff, 1'b0, 40);
    for (int i = 0; i < 20; i++) begin
      do_write(5'(1 + $urandom_range(7)), 8'($urandom), 1'b0, 40);
    end
    do_write(5'h02, 8'ha5, 1'b1, 40);
    do_read(5'h03, 1'b1);
    do_write(5'h04, 8'h5a, 1'b0, 39);
    do_write(5'h04, 8'h5a, 1'b0, 41);
    @(negedge ref_clk) vcc_uv = 1'b1;
    repeat (4) @(negedge ref_clk);
    do_write(5'h06, 8'h02, 1'b0, 40);
    do_write(5'h04, 8'h33, 1'b0, 39);
    @(negedge ref_clk) vcc_uv = 1'b0;
    repeat (4) @(negedge ref_clk);
    do_read(5'h06, 1'b0);
    finish_test();
  end
endmodule : tb_spi_crc_register_port
`default_nettype wire
